// [pkg/rsc_pkg.sv]
// package: constants and types for the reset state controller
package rsc_pkg;
   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int         RSC_PC_W       = 12;
   localparam int         RSC_SP_W       = 3;
   localparam int         RSC_PORT_W     = 8;
   localparam int         RSC_AN_W       = 14;
   localparam int         RSC_TM_W       = 4;
   localparam int         RSC_INT_W      = 8;
   localparam logic [7:0] RSC_PORT_RST   = 8'hff;
   localparam logic [13:0] RSC_AN_RST    = 14'h3fff;
   localparam logic [2:0] RSC_SP_TOP     = 3'h0;
   localparam logic [11:0] RSC_PC_RST    = 12'h000;
   localparam logic [1:0] RSC_SYNC_INIT  = 2'h0;

   // reset causes as decoded by the cause selector
   typedef enum logic [2:0] {
      RSC_CAUSE_NONE,
      RSC_CAUSE_POR,
      RSC_CAUSE_LVR,
      RSC_CAUSE_WDT_RUN,
      RSC_CAUSE_WDT_SLEEP
   } rsc_cause_t;
endpackage

// [design/rsc_cause_sel.sv]
// module: synchronises and prioritises the reset cause strobes
`timescale 1ns/1ns
module rsc_cause_sel
   import rsc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // raw cause levels from analog / watchdog blocks
   input  wire logic       por_req,
   input  wire logic       lvr_req,
   input  wire logic       wdt_req,
   input  wire logic       in_low_power,
   // decoded cause, one-cycle pulse
   output rsc_cause_t      cause
);
   logic [1:0] sync_por;
   logic [1:0] sync_lvr;
   logic [1:0] sync_wdt;
   logic [1:0] sync_lp;
   logic       prev_por;
   logic       prev_lvr;
   logic       prev_wdt;

   // ------------------------------------------------------------
   // two-stage synchronisers, first stage read only by the second
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sync_por <= RSC_SYNC_INIT;
         sync_lvr <= RSC_SYNC_INIT;
         sync_wdt <= RSC_SYNC_INIT;
         sync_lp  <= RSC_SYNC_INIT;
      end
      else
      begin
         sync_por <= {sync_por[0], por_req};
         sync_lvr <= {sync_lvr[0], lvr_req};
         sync_wdt <= {sync_wdt[0], wdt_req};
         sync_lp  <= {sync_lp[0], in_low_power};
      end
   end

   // edge history for rising-edge detection
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_por <= 1'b0;
         prev_lvr <= 1'b0;
         prev_wdt <= 1'b0;
      end
      else
      begin
         prev_por <= sync_por[1];
         prev_lvr <= sync_lvr[1];
         prev_wdt <= sync_wdt[1];
      end
   end

   // power-on beats low voltage beats watchdog when they coincide
   always_comb
   begin
      cause = RSC_CAUSE_NONE;
      if (sync_por[1] && !prev_por)
         cause = RSC_CAUSE_POR;
      else if (sync_lvr[1] && !prev_lvr)
         cause = RSC_CAUSE_LVR;
      else if (sync_wdt[1] && !prev_wdt)
         cause = sync_lp[1] ? RSC_CAUSE_WDT_SLEEP : RSC_CAUSE_WDT_RUN;
   end
endmodule

// [design/rsc_top.sv]
// module: reset state controller applying per-cause reset state
`timescale 1ns/1ns
module rsc_top
   import rsc_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // reset cause inputs, asynchronous levels
   input  wire logic                  por_req,
   input  wire logic                  lvr_req,
   input  wire logic                  wdt_req,
   input  wire logic                  in_low_power,
   // software controls, same clock
   input  wire logic                  sw_clr_lvr_flag,
   input  wire logic                  sw_set_to_flag_clr,
   input  wire logic [RSC_INT_W-1:0]  sw_int_en_wr,
   input  wire logic                  sw_int_en_we,
   input  wire logic [RSC_TM_W-1:0]   sw_tm_on_wr,
   input  wire logic                  sw_tm_on_we,
   input  wire logic [RSC_PORT_W-1:0] sw_port_dir_wr,
   input  wire logic                  sw_port_dir_we,
   input  wire logic                  sleep_enter,
   // applied state
   output logic                       timeout_flag,
   output logic                       power_down_flag,
   output logic                       low_voltage_reset_flag,
   output logic [RSC_PC_W-1:0]        pc_value,
   output logic [RSC_SP_W-1:0]        sp_value,
   output logic                       pc_load,
   output logic [RSC_INT_W-1:0]       int_enable,
   output logic                       watchdog_timer_clear,
   output logic [RSC_TM_W-1:0]        timer_on,
   output logic [RSC_PORT_W-1:0]      port_data,
   output logic [RSC_PORT_W-1:0]      port_dir,
   output logic [RSC_AN_W-1:0]        analog_input_pins
);
   rsc_cause_t cause;
   logic       full_rst;
   logic       any_rst;

   // ------------------------------------------------------------
   // cause decode
   // ------------------------------------------------------------
   rsc_cause_sel u_cause
   (
      .clk_sys      (clk_sys),
      .nrst         (nrst),
      .por_req      (por_req),
      .lvr_req      (lvr_req),
      .wdt_req      (wdt_req),
      .in_low_power (in_low_power),
      .cause        (cause)
   );

   // ------------------------------------------------------------
   // cause classification
   // ------------------------------------------------------------
   // the three full causes reload the register defaults; only the
   // sleep watchdog expiry leaves state alone, so a sleeping program
   // keeps its enables and port setup across the pc and sp restart
   function automatic logic rsc_full_reset(input rsc_cause_t c);
      case (c)
         RSC_CAUSE_POR:     return 1'b1;
         RSC_CAUSE_LVR:     return 1'b1;
         RSC_CAUSE_WDT_RUN: return 1'b1;
         default:           return 1'b0;
      endcase
   endfunction

   // any decoded cause, partial or full
   function automatic logic rsc_any_reset(input rsc_cause_t c);
      return rsc_full_reset(c) || (c == RSC_CAUSE_WDT_SLEEP);
   endfunction

   // a sleep watchdog expiry is the only partial reset
   assign full_rst = rsc_full_reset(cause);
   assign any_rst  = rsc_any_reset(cause);

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // a decoded cause outranks a software clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         timeout_flag <= 1'b0;
      else
         case (cause)
            RSC_CAUSE_POR:       timeout_flag <= 1'b0;
            RSC_CAUSE_WDT_RUN:   timeout_flag <= 1'b1;
            RSC_CAUSE_WDT_SLEEP: timeout_flag <= 1'b1;
            RSC_CAUSE_LVR:       timeout_flag <= timeout_flag;
            default:
               if (sw_set_to_flag_clr)
                  timeout_flag <= 1'b0;
         endcase
   end

   // power-down flag also set by entering sleep, as the cpu does
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         power_down_flag <= 1'b0;
      else
         case (cause)
            RSC_CAUSE_POR:       power_down_flag <= 1'b0;
            RSC_CAUSE_WDT_SLEEP: power_down_flag <= 1'b1;
            RSC_CAUSE_WDT_RUN:   power_down_flag <= power_down_flag;
            RSC_CAUSE_LVR:       power_down_flag <= power_down_flag;
            default:
               if (sleep_enter)
                  power_down_flag <= 1'b1;
               else if (sw_set_to_flag_clr)
                  power_down_flag <= 1'b0;
         endcase
   end

   // set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         low_voltage_reset_flag <= 1'b0;
      else if (cause == RSC_CAUSE_LVR)
         low_voltage_reset_flag <= 1'b1;
      else if (sw_clr_lvr_flag)
         low_voltage_reset_flag <= 1'b0;
   end

   // ------------------------------------------------------------
   // program counter and stack pointer
   // ------------------------------------------------------------
   // pc_load is a one-cycle strobe telling the core to refetch the vector
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pc_value <= RSC_PC_RST;
         sp_value <= RSC_SP_TOP;
         pc_load  <= 1'b0;
      end
      else
      begin
         pc_load <= any_rst;
         if (any_rst)
         begin
            pc_value <= RSC_PC_RST;
            sp_value <= RSC_SP_TOP;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts, timers, watchdog
   // ------------------------------------------------------------
   // interrupts stay masked until software writes the enables back
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         int_enable <= '0;
      else if (full_rst)
         int_enable <= '0;
      else if (sw_int_en_we)
         int_enable <= sw_int_en_wr;
   end

   // timers stay stopped until software turns them on again
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         timer_on <= '0;
      else if (full_rst)
         timer_on <= '0;
      else if (sw_tm_on_we)
         timer_on <= sw_tm_on_wr;
   end

   // one-cycle clear; the watchdog counts again on the next edge
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         watchdog_timer_clear <= 1'b0;
      else
         watchdog_timer_clear <= any_rst;
   end

   // ------------------------------------------------------------
   // ports: inputs and analog selected on a full reset
   // ------------------------------------------------------------
   // port_data has no software path here; the core owns the latches
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         port_data         <= RSC_PORT_RST;
         port_dir          <= RSC_PORT_RST;
         analog_input_pins <= RSC_AN_RST;
      end
      else if (full_rst)
      begin
         port_data         <= RSC_PORT_RST;
         port_dir          <= RSC_PORT_RST;
         analog_input_pins <= RSC_AN_RST;
      end
      else if (sw_port_dir_we)
         port_dir <= sw_port_dir_wr;
   end
endmodule

// [dv/rsc_assertions.sv]
// checker: timing properties on the reset state controller ports
`timescale 1ns/1ns
module rsc_assertions
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  nrst,
   // applied state
   input wire logic                  timeout_flag,
   input wire logic                  power_down_flag,
   input wire logic                  low_voltage_reset_flag,
   input wire logic [RSC_PC_W-1:0]   pc_value,
   input wire logic [RSC_SP_W-1:0]   sp_value,
   input wire logic                  pc_load,
   input wire logic [RSC_INT_W-1:0]  int_enable,
   input wire logic                  watchdog_timer_clear,
   input wire logic [RSC_TM_W-1:0]   timer_on,
   input wire logic [RSC_PORT_W-1:0] port_data,
   input wire logic [RSC_PORT_W-1:0] port_dir,
   input wire logic [RSC_AN_W-1:0]   analog_input_pins
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // apply strobe must be a single cycle, else state is reloaded twice
   sequence s_apply;
      pc_load ##1 !pc_load;
   endsequence
   pc_pulse_a: assert property (pc_load |-> s_apply)
      else $error("apply strobe not one cycle");
   wdt_pulse_a: assert property (watchdog_timer_clear |=> !watchdog_timer_clear)
      else $error("watchdog clear not one cycle");
   wdt_restart_a: assert property (pc_load |-> watchdog_timer_clear)
      else $error("watchdog not cleared on reset");
   reset_ptr_a: assert property (pc_load |-> pc_value == 12'h000 && sp_value == 3'h0)
      else $error("pc or sp not cleared");
   to_cause_a: assert property ($rose(timeout_flag) |-> pc_load)
      else $error("timeout flag set without reset");
   lvr_state_a: assert property ($rose(low_voltage_reset_flag) |->
      pc_load && $stable(timeout_flag) && $stable(power_down_flag))
      else $error("low voltage reset altered flags");
   sleep_keep_a: assert property (pc_load && $rose(power_down_flag) |->
      timeout_flag && $stable(int_enable) && $stable(port_dir))
      else $error("sleep watchdog reset altered state");
   irq_off_a: assert property (pc_load && !power_down_flag |->
      int_enable == 8'h00 && timer_on == 4'h0)
      else $error("interrupts or timers left on");
   port_input_a: assert property (pc_load && !power_down_flag |-> port_dir == 8'hff
      && port_data == 8'hff && analog_input_pins == 14'h3fff)
      else $error("ports not made inputs");
endmodule
bind rsc_top rsc_assertions u_chk (.clk_sys, .nrst, .timeout_flag, .power_down_flag,
   .low_voltage_reset_flag, .pc_value, .sp_value, .pc_load, .int_enable,
   .watchdog_timer_clear, .timer_on, .port_data, .port_dir, .analog_input_pins);

// [dv/reset_state_controller_bench.sv]
// bench: directed reset cause sequences for the reset state controller
`timescale 1ns/1ns
module reset_state_controller_bench
   import rsc_pkg::*;
;
   logic clk_sys = 1'b0, nrst = 1'b0, por_req = 1'b0, lvr_req = 1'b0, wdt_req = 1'b0;
   logic in_low_power = 1'b0, sw_clr_lvr_flag = 1'b0, sw_set_to_flag_clr = 1'b0;
   logic sw_int_en_we = 1'b0, sw_tm_on_we = 1'b0;
   logic sw_port_dir_we = 1'b0, sleep_enter = 1'b0, timeout_flag, power_down_flag;
   logic low_voltage_reset_flag, pc_load, watchdog_timer_clear;
   logic [7:0] sw_int_en_wr = 8'h00, sw_port_dir_wr = 8'h00, int_enable, port_data, port_dir;
   logic [3:0] sw_tm_on_wr = 4'h0, timer_on;
   logic [11:0] pc_value;
   logic [2:0] sp_value;
   logic [13:0] analog_input_pins;
   int n_mismatch = 0, total_checks = 0;
   rsc_top dut
   (
      .clk_sys                (clk_sys),
      .nrst                   (nrst),
      .por_req                (por_req),
      .lvr_req                (lvr_req),
      .wdt_req                (wdt_req),
      .in_low_power           (in_low_power),
      .sw_clr_lvr_flag        (sw_clr_lvr_flag),
      .sw_set_to_flag_clr     (sw_set_to_flag_clr),
      .sw_int_en_wr           (sw_int_en_wr),
      .sw_int_en_we           (sw_int_en_we),
      .sw_tm_on_wr            (sw_tm_on_wr),
      .sw_tm_on_we            (sw_tm_on_we),
      .sw_port_dir_wr         (sw_port_dir_wr),
      .sw_port_dir_we         (sw_port_dir_we),
      .sleep_enter            (sleep_enter),
      .timeout_flag           (timeout_flag),
      .power_down_flag        (power_down_flag),
      .low_voltage_reset_flag (low_voltage_reset_flag),
      .pc_value               (pc_value),
      .sp_value               (sp_value),
      .pc_load                (pc_load),
      .int_enable             (int_enable),
      .watchdog_timer_clear   (watchdog_timer_clear),
      .timer_on               (timer_on),
      .port_data              (port_data),
      .port_dir               (port_dir),
      .analog_input_pins      (analog_input_pins)
   );
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // free running clock
   initial
   begin
      forever #25 clk_sys = ~clk_sys;
   end
   // drive always 5 ns after the edge so sampling never races
   task automatic tick;
      @(posedge clk_sys);
      #5;
   endtask
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [3:0] t, input logic [7:0] d);
      {sw_int_en_wr, sw_tm_on_wr, sw_port_dir_wr} = {i, t, d};
      {sw_int_en_we, sw_tm_on_we, sw_port_dir_we} = 3'h7;
      tick;
      {sw_int_en_we, sw_tm_on_we, sw_port_dir_we} = 3'h0;
      tick;
   endtask
   task automatic st(input logic t, p, l, input logic [7:0] i, input logic [3:0] m,
      input logic [7:0] d);
      chk("timeout", timeout_flag, t);
      chk("pdown", power_down_flag, p);
      chk("lvflag", low_voltage_reset_flag, l);
      chk("int_en", int_enable, i);
      chk("timer", timer_on, m);
      chk("dir", port_dir, d);
   endtask
   // raise one cause, wait a bounded time for the apply strobe
   task automatic cause(input int k, input logic lp);
      int w;
      in_low_power = lp;
      tick;
      if (k == 0) por_req = 1'b1;
      else if (k == 1) lvr_req = 1'b1;
      else wdt_req = 1'b1;
      for (w = 0; w < 10 && pc_load !== 1'b1; w++) tick;
      chk("pc_load", pc_load, 1'b1);
      chk("pc", pc_value, RSC_PC_RST);
      chk("sp", sp_value, RSC_SP_TOP);
      chk("wdt_clr", watchdog_timer_clear, 1'b1);
      if (!lp) chk("pdata", port_data, 8'hff);
      if (!lp) chk("analog", analog_input_pins, 14'h3fff);
      {por_req, lvr_req, wdt_req} = 3'h0;
      repeat (4) tick;
      in_low_power = 0;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog: the sequence needs some 50 cycles, allow 2000
   initial
   begin
      #100000;
      n_mismatch++;
      results;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      #5 nrst = 1;
      tick;
      st(0, 0, 0, 8'h00, 4'h0, 8'hff);
      wr(8'hff, 4'hf, 8'h00);
      sleep_enter = 1;
      tick;
      sleep_enter = 0;
      cause(2, 0);
      st(1, 1, 0, 8'h00, 4'h0, 8'hff);
      sw_set_to_flag_clr = 1;
      tick;
      sw_set_to_flag_clr = 0;
      wr(8'hff, 4'hf, 8'h00);
      cause(2, 1);
      st(1, 1, 0, 8'hff, 4'hf, 8'h00);
      cause(1, 0);
      st(1, 1, 1, 8'h00, 4'h0, 8'hff);
      sw_clr_lvr_flag = 1;
      tick;
      sw_clr_lvr_flag = 0;
      tick;
      chk("lvflag", low_voltage_reset_flag, 1'b0);
      wr(8'hff, 4'hf, 8'h00);
      cause(0, 0);
      st(0, 0, 0, 8'h00, 4'h0, 8'hff);
      // second asynchronous reset mid-run, with the power-down flag and enables set
      wr(8'hff, 4'hf, 8'h00);
      sleep_enter = 1'b1;
      tick;
      sleep_enter = 1'b0;
      nrst = 1'b0;
      tick;
      nrst = 1'b1;
      tick;
      st(0, 0, 0, 8'h00, 4'h0, 8'hff);
      results;
   end
endmodule
